// ---- pph_port.sv ----
// Four-port sixteen-line parallel handshake port with APB registers
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module pph_port (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pph_pkg::ADDR_W-1:0] paddr,
   input wire logic [pph_pkg::DATA_W-1:0] pwdata,
   output logic [pph_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pph_pkg::NPORT*pph_pkg::PORT_W-1:0] io_in,
   output logic [pph_pkg::NPORT*pph_pkg::PORT_W-1:0] io_out,
   output logic [pph_pkg::NPORT-1:0] io_oe,
   output logic [pph_pkg::NPORT-1:0] device_ready,
   output logic [pph_pkg::NPORT-1:0] device_reply,
   input wire logic [pph_pkg::NPORT-1:0] peer_ready,
   input wire logic [pph_pkg::NPORT-1:0] peer_reply,
   input wire logic reply_interrupt_jumper,
   output logic irq
);
   import pph_pkg::*;

   localparam int SW = NPORT * PORT_W + 2 * NPORT + 1;
   localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC - 1);
   localparam logic [CNT_W-1:0] RPLY_LOAD = CNT_W'(RPLY_CYC - 1);

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic [IDX_W-1:0] port_idx(
      input logic [IDX_W-1:0] base, input int p);
      port_idx = base + IDX_W'(p) * IDX_PORT_STRIDE;
   endfunction

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   logic [PORT_W-1:0] dbr_ff [NPORT];
   pph_hs_t st_ff [NPORT];
   pph_hs_t nxt_st [NPORT];
   logic [CNT_W-1:0] cnt_ff [NPORT];
   logic [CNT_W-1:0] nxt_cnt [NPORT];
   logic [NPORT-1:0] dir_ff;
   logic [NPORT-1:0] rdy_ff;
   logic [NPORT-1:0] rply_ff;
   logic [NPORT-1:0] have_ff;
   logic [NPORT-1:0] nxt_have;
   logic int_en_ff;
   logic [PORT_W-1:0] pend_ff;
   logic [PORT_W-1:0] nxt_pend;
   logic [PORT_W-1:0] mask_ff;
   logic irq_ff;
   logic [PORT_W-1:0] a_prev_ff;
   logic [NPORT-1:0] prply_prev_ff;
   logic [DATA_W-1:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;

   // ------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------
   logic [SW-1:0] sync_q;
   logic [NPORT*PORT_W-1:0] lines_s;
   logic [NPORT-1:0] prdy_s;
   logic [NPORT-1:0] prply_s;
   logic jmp_s;

   pph_sync3 #(.W(SW)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({reply_interrupt_jumper, peer_ready, peer_reply, io_in}),
      .q(sync_q)
   );

   assign lines_s = sync_q[NPORT*PORT_W-1:0];
   assign prply_s = sync_q[NPORT*PORT_W +: NPORT];
   assign prdy_s = sync_q[NPORT*PORT_W+NPORT +: NPORT];
   assign jmp_s = sync_q[SW-1];

   // ------------------------------------------------------------------
   // Edge detection and interrupt sources
   // ------------------------------------------------------------------
   logic [PORT_W-1:0] a_rise;
   logic [NPORT-1:0] prply_rise;
   logic [PORT_W-1:0] irq_src;
   logic [PORT_W-1:0] irq_take;

   assign a_rise = lines_s[PORT_W-1:0] & ~a_prev_ff;
   assign prply_rise = prply_s & ~prply_prev_ff;
   // Jumper routes the four replies into the top request slots
   assign irq_src = jmp_s ?
      {prply_rise, a_rise[IRQ_LINE_BITS-1:0]} : a_rise;
   assign irq_take = int_en_ff ? irq_src : '0;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   logic setup_ph;
   logic acc_ph;
   logic wr_acc;
   logic rd_acc;
   logic [IDX_W-1:0] idx;
   logic aligned;
   logic [NPORT-1:0] csr_hit;
   logic [NPORT-1:0] dbr_hit;
   logic pend_hit;
   logic mask_hit;
   logic any_hit;

   assign setup_ph = psel & ~penable;
   assign acc_ph = psel & penable & pready_ff;
   assign wr_acc = acc_ph & pwrite;
   assign rd_acc = acc_ph & ~pwrite;
   assign idx = paddr[ADDR_W-1:2];
   assign aligned = (paddr[1:0] == 2'b00);
   assign pend_hit = aligned & (idx == IDX_PEND);
   assign mask_hit = aligned & (idx == IDX_MASK);
   assign any_hit = |csr_hit | |dbr_hit | pend_hit | mask_hit;

   genvar g;
   generate
      for (g = 0; g < NPORT; g++) begin : g_addr
         assign csr_hit[g] = aligned & (idx == port_idx(IDX_CSR_A, g));
         assign dbr_hit[g] = aligned & (idx == port_idx(IDX_DBR_A, g));
      end
   endgenerate

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   logic [PORT_W-1:0] rd_val;

   always_comb begin
      logic [PORT_W-1:0] csr;
      csr = '0;
      rd_val = '0;
      for (int p = 0; p < NPORT; p++) begin
         csr = '0;
         csr[CSR_DIR_BIT] = dir_ff[p];
         csr[CSR_PRDY_BIT] = prdy_s[p];
         csr[CSR_PRPLY_BIT] = prply_s[p];
         csr[CSR_BUSY_BIT] = (st_ff[p] != HS_IDLE);
         csr[CSR_HAVE_BIT] = have_ff[p];
         if (p == 0) begin
            csr[CSR_INT_EN_BIT] = int_en_ff;
            csr[CSR_GROUP_BIT] = |pend_ff;
         end
         if (csr_hit[p]) begin
            rd_val = csr;
         end
         if (dbr_hit[p]) begin
            // Input reads the live lines; output reads back the buffer
            rd_val = dir_ff[p] ? dbr_ff[p]
               : lines_s[p*PORT_W +: PORT_W];
         end
      end
      if (pend_hit) begin
         rd_val = pend_ff;
      end
      if (mask_hit) begin
         rd_val = mask_ff;
      end
   end

   // ------------------------------------------------------------------
   // Handshake engines
   // ------------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         nxt_st[p] = st_ff[p];
         nxt_cnt[p] = cnt_ff[p];
         // A fresh reply wins over the clear from a starting ack
         nxt_have[p] = have_ff[p];
         unique case (st_ff[p])
            HS_IDLE: begin
               if (wr_acc & dbr_hit[p] & dir_ff[p] & prdy_s[p]) begin
                  nxt_st[p] = HS_SETUP;
                  nxt_cnt[p] = SETUP_LOAD;
               end else if (rd_acc & dbr_hit[p] & ~dir_ff[p]
                            & have_ff[p]) begin
                  nxt_st[p] = HS_REPLY;
                  nxt_cnt[p] = RPLY_LOAD;
                  nxt_have[p] = 1'b0;
               end
            end
            HS_SETUP: begin
               if (cnt_ff[p] == '0) begin
                  nxt_st[p] = HS_REPLY;
                  nxt_cnt[p] = RPLY_LOAD;
               end else begin
                  nxt_cnt[p] = cnt_ff[p] - 1'b1;
               end
            end
            HS_REPLY: begin
               if (cnt_ff[p] == '0) begin
                  nxt_st[p] = HS_IDLE;
               end else begin
                  nxt_cnt[p] = cnt_ff[p] - 1'b1;
               end
            end
         endcase
         if (prply_rise[p] & ~dir_ff[p]) begin
            nxt_have[p] = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Interrupt status, set wins over write-one-to-clear
   // ------------------------------------------------------------------
   logic [PORT_W-1:0] w1c;

   assign w1c = (wr_acc & pend_hit) ? pwdata[PORT_W-1:0] : '0;
   assign nxt_pend = (pend_ff & ~w1c) | irq_take;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int p = 0; p < NPORT; p++) begin
            dbr_ff[p] <= DBR_RST;
            st_ff[p] <= HS_IDLE;
            cnt_ff[p] <= '0;
         end
         dir_ff <= {NPORT{DIR_RST}};
         rdy_ff <= {NPORT{~DIR_RST}};
         rply_ff <= '0;
         have_ff <= '0;
         int_en_ff <= INT_EN_RST;
      end else begin
         for (int p = 0; p < NPORT; p++) begin
            st_ff[p] <= nxt_st[p];
            cnt_ff[p] <= nxt_cnt[p];
            rply_ff[p] <= (nxt_st[p] == HS_REPLY);
            if (wr_acc & dbr_hit[p]) begin
               dbr_ff[p] <= pwdata[PORT_W-1:0];
            end
            if (wr_acc & csr_hit[p]) begin
               // Ready and drivers only turn round on a direction change
               dir_ff[p] <= pwdata[CSR_DIR_BIT];
               rdy_ff[p] <= ~pwdata[CSR_DIR_BIT];
            end
         end
         have_ff <= nxt_have;
         if (wr_acc & csr_hit[0]) begin
            int_en_ff <= pwdata[CSR_INT_EN_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= PEND_RST;
         mask_ff <= MASK_RST;
         irq_ff <= 1'b0;
         a_prev_ff <= '0;
         prply_prev_ff <= '0;
      end else begin
         pend_ff <= nxt_pend;
         if (wr_acc & mask_hit) begin
            mask_ff <= pwdata[PORT_W-1:0];
         end
         irq_ff <= int_en_ff & |(nxt_pend & mask_ff);
         a_prev_ff <= lines_s[PORT_W-1:0];
         prply_prev_ff <= prply_s;
      end
   end

   // No wait state, yet every APB output comes straight from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= setup_ph;
         if (setup_ph) begin
            prdata_ff <= pwrite ? '0 : DATA_W'(rd_val);
            pslverr_ff <= ~any_hit;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   generate
      for (g = 0; g < NPORT; g++) begin : g_out
         assign io_out[g*PORT_W +: PORT_W] = dbr_ff[g];
      end
   endgenerate

   assign io_oe = dir_ff;
   assign device_ready = rdy_ff;
   assign device_reply = rply_ff;
   assign irq = irq_ff;
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
endmodule

// ---- pph_pkg.sv ----
// Shared constants and types for the parallel handshake port block
package pph_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int NPORT = 4;
   localparam int PORT_W = 16;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_W = 6;
   localparam int CNT_W = 5;

   // ------------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_CSR_A = 6'h00;
   localparam logic [IDX_W-1:0] IDX_DBR_A = 6'h02;
   localparam logic [IDX_W-1:0] IDX_PORT_STRIDE = 6'h04;
   localparam logic [IDX_W-1:0] IDX_PEND = 6'h10;
   localparam logic [IDX_W-1:0] IDX_MASK = 6'h11;

   // ------------------------------------------------------------------
   // Control/status field positions
   // ------------------------------------------------------------------
   localparam int CSR_GROUP_BIT = 15;
   localparam int CSR_INT_EN_BIT = 9;
   localparam int CSR_DIR_BIT = 8;
   localparam int CSR_PRDY_BIT = 7;
   localparam int CSR_PRPLY_BIT = 6;
   localparam int CSR_BUSY_BIT = 5;
   localparam int CSR_HAVE_BIT = 4;
   localparam int IRQ_LINE_BITS = 12;

   // ------------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------------
   localparam logic [PORT_W-1:0] DBR_RST = 16'h0000;
   localparam logic [PORT_W-1:0] MASK_RST = 16'h0000;
   localparam logic [PORT_W-1:0] PEND_RST = 16'h0000;
   localparam logic DIR_RST = 1'b0;
   localparam logic INT_EN_RST = 1'b0;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_MHZ = 40;
   localparam int T_SETUP_NS = 300;
   localparam int T_RPLY_NS = 410;
   localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int RPLY_CYC = (T_RPLY_NS * CLK_MHZ + 999) / 1000;

   // ------------------------------------------------------------------
   // Handshake states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_SETUP = 3'b010,
      HS_REPLY = 3'b100
   } pph_hs_t;

endpackage

// ---- pph_sync3.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pph_sync3 #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] q_ff;
   logic [W-1:0] agree;

   // Only the second stage reads the first, against metastability
   assign agree = ~(s2_ff ^ s3_ff);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         q_ff <= '0;
      end else begin
         s1_ff <= d;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         q_ff <= (agree & s3_ff) | (~agree & q_ff);
      end
   end

   assign q = q_ff;
endmodule

// ---- pph_checker.sv ----
// Concurrent checks on the parallel port block pins
`timescale 1ns/1ps
module pph_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pph_pkg::ADDR_W-1:0] paddr,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [pph_pkg::NPORT*pph_pkg::PORT_W-1:0] io_out,
   input wire logic [pph_pkg::NPORT-1:0] io_oe,
   input wire logic [pph_pkg::NPORT-1:0] device_ready,
   input wire logic [pph_pkg::NPORT-1:0] device_reply
);
   import pph_pkg::*;
   logic [4:0] rl_ff;
   logic [4:0] nxt_rl;
   wire logic rd_a = psel && penable && pready && !pwrite && paddr == 8'h08;
   wire logic wr_b = psel && penable && pready && pwrite && paddr == 8'h18;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Pulse length counted here, a repetition of 17 would be too costly
   assign nxt_rl = device_reply[0] ? rl_ff + 5'h01 : 5'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rl_ff <= 5'h00;
      end else begin
         rl_ff <= nxt_rl;
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_done;
      psel && penable && pready;
   endsequence
   sequence s_out_go;
      $rose(device_reply[1]) ##0 io_oe[1];
   endsequence
   property p_ready_oe;
      device_ready == ~io_oe;
   endproperty
   property p_apb_ans;
      s_setup |=> s_done;
   endproperty
   property p_apb_one;
      pready |=> !pready;
   endproperty
   property p_apb_err;
      psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr;
   endproperty
   property p_in_ack;
      $rose(device_reply[0]) |-> $past(rd_a);
   endproperty
   property p_reply_len;
      $fell(device_reply[0]) |-> rl_ff == 5'h11;
   endproperty
   property p_out_setup;
      s_out_go |-> $past(wr_b, 13);
   endproperty
   property p_out_hold;
      s_out_go |-> io_out[31:16] == $past(io_out[31:16], 11);
   endproperty
   a_ready_oe: assert property (p_ready_oe)
      else $error("drivers on while ready");
   a_apb_ans: assert property (p_apb_ans)
      else $error("no answer after setup");
   a_apb_one: assert property (p_apb_one)
      else $error("pready longer than one cycle");
   a_apb_err: assert property (p_apb_err)
      else $error("misaligned access not refused");
   a_in_ack: assert property (p_in_ack)
      else $error("input reply without buffer read");
   a_reply_len: assert property (p_reply_len)
      else $error("reply pulse length wrong");
   a_out_setup: assert property (p_out_setup)
      else $error("output reply not 13 cycles after write");
   a_out_hold: assert property (p_out_hold)
      else $error("output data moved before reply");
endmodule

// ---- pph_peer.sv ----
// Behavioural far-side device for one port
`timescale 1ns/1ps
module pph_peer (
   input wire logic pclk,
   input wire logic dev_rdy,
   input wire logic dev_rpl,
   input wire logic [15:0] line_out,
   input wire logic start,
   input wire logic [15:0] word,
   input wire logic want,
   output logic [15:0] line_in,
   output logic rdy,
   output logic rpl,
   output logic [15:0] got
);
   assign rdy = want;
   initial begin
      line_in = 16'h0000;
      rpl = 1'b0;
      got = 16'h0000;
      forever begin
         @(posedge pclk);
         if (start && dev_rdy) begin
            line_in <= word;
            @(posedge pclk);
            rpl <= 1'b1;
            while (!dev_rpl) @(posedge pclk);
            while (dev_rpl) @(posedge pclk);
            // Released lines show the inverse, never a stale word
            line_in <= ~word;
            rpl <= 1'b0;
         end else if (dev_rpl && !dev_rdy) begin
            got <= line_out;
            @(posedge pclk);
            rpl <= 1'b1;
            while (dev_rpl) @(posedge pclk);
            rpl <= 1'b0;
         end
      end
   end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the parallel handshake port
`timescale 1ns/1ps
module tb_top;
   import pph_pkg::*;
   typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} pph_exp_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 8'h00;
   logic [DATA_W-1:0] pwdata = 32'h0000_0000;
   logic [DATA_W-1:0] prdata;
   logic pready, pslverr, irq, pa_rdy, pa_rpl, pb_rdy, pb_rpl;
   logic [NPORT*PORT_W-1:0] io_out;
   logic [NPORT-1:0] io_oe, device_ready, device_reply;
   logic jumper = 1'b0;
   logic start_a = 1'b0;
   logic want_b = 1'b0;
   logic [15:0] word_a = 16'h0000;
   logic [15:0] pa_line, pb_line, pb_got;
   logic [1:0] rdy_cd = 2'b00;
   logic [31:0] cd_lines = 32'h0000_0000;
   logic [31:0] v;
   wire logic [NPORT*PORT_W-1:0] src = {cd_lines, pb_line, pa_line};
   wire logic [NPORT*PORT_W-1:0] io_in;
   wire logic [NPORT-1:0] peer_ready = {rdy_cd, pb_rdy, pa_rdy};
   wire logic [NPORT-1:0] peer_reply = {2'b00, pb_rpl, pa_rpl};
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 85;
   pph_exp_t exp_q[$];
   pph_exp_t e;
   // Each wire shows whoever drives it
   for (genvar p = 0; p < NPORT; p++) begin : g_ln
      assign io_in[16*p +: 16] =
         io_oe[p] ? io_out[16*p +: 16] : src[16*p +: 16];
   end
   always #12.5 pclk = ~pclk;
   pph_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe), .device_ready(device_ready),
      .device_reply(device_reply), .peer_ready(peer_ready),
      .peer_reply(peer_reply), .reply_interrupt_jumper(jumper), .irq(irq));
   pph_peer peer_a (.pclk(pclk), .dev_rdy(device_ready[0]),
      .dev_rpl(device_reply[0]), .line_out(io_out[15:0]), .start(start_a),
      .word(word_a), .want(1'b0), .line_in(pa_line), .rdy(pa_rdy),
      .rpl(pa_rpl), .got());
   pph_peer peer_b (.pclk(pclk), .dev_rdy(device_ready[1]),
      .dev_rpl(device_reply[1]), .line_out(io_out[31:16]), .start(1'b0),
      .word(16'h0000), .want(want_b), .line_in(pb_line), .rdy(pb_rdy),
      .rpl(pb_rpl), .got(pb_got));
   task chk(input string what, input logic [31:0] ex, input logic [31:0] got);
      total_checks++;
      if (got !== ex) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, ex, got);
      end
   endtask
   task end_sim;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task waitc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [31:0] ed, input logic ee);
      exp_q.push_back({ed, m, ee});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'hFFFF_FFFF, 32'h0000_0000, 1'b0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed);
      apb(1'b0, a, 32'h0000_0000, m, ed, 1'b0);
   endtask
   task in_hs(input logic [15:0] w, input logic [31:0] pm,
      input logic [31:0] pe, input logic g);
      word_a <= w;
      start_a <= 1'b1;
      @(posedge pclk);
      start_a <= 1'b0;
      waitc(10);
      rd(8'h00, 32'h0000_8010, {16'h0000, g, 10'h000, 1'b1, 4'h0});
      rd(8'h40, pm, pe);
      rd(8'h08, 32'h0000_FFFF, {16'h0000, w});
      while (device_reply[0] !== 1'b0) @(posedge pclk);
      waitc(6);
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready) begin
         e = exp_q.pop_front();
         chk("prdata", e.d, prdata & e.m);
         chk("pslverr", {31'h0, e.e}, {31'h0, pslverr});
      end
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   initial begin
      waitc(8);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("device_ready", 32'hF, {28'h0, device_ready});
      rd(8'h00, 32'h0000_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h4C, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
      apb(1'b1, 8'h09, 32'hFFFF, 32'hFFFF_FFFF, 32'h0, 1'b1);
      repeat (2) begin
         v = $random(seed);
         cd_lines[15:0] <= v[15:0];
         waitc(6);
         rd(8'h28, 32'hFFFF_FFFF, {16'h0000, v[15:0]});
      end
      chk("device_reply", 32'h0, {28'h0, device_reply});
      rdy_cd[1] <= 1'b1;
      wr(8'h30, 32'h0000_0100);
      v = $random(seed);
      wr(8'h38, {16'h0000, v[15:0]});
      chk("io_out_d", {16'h0, v[15:0]}, {16'h0, io_out[63:48]});
      rd(8'h38, 32'h0000_FFFF, {16'h0000, v[15:0]});
      jumper <= 1'b1;
      wr(8'h44, 32'h0000_FFFF);
      v = $random(seed);
      in_hs(v[15:0], 32'h0000_FFFF, 32'h0, 1'b0);
      wr(8'h00, 32'h0000_0200);
      wr(8'h44, 32'h0000_1000);
      v = $random(seed);
      in_hs(v[15:0], 32'h0000_1000, 32'h0000_1000, 1'b1);
      chk("irq", 32'h1, {31'h0, irq});
      jumper <= 1'b0;
      wr(8'h40, 32'h0000_FFFF);
      waitc(2);
      chk("irq", 32'h0, {31'h0, irq});
      // Same word as the idle lines and the jumper off, so nothing should raise a request
      in_hs(~v[15:0], 32'h0000_FFFF, 32'h0, 1'b0);
      wr(8'h10, 32'h0000_0100);
      want_b <= 1'b1;
      waitc(6);
      rd(8'h10, 32'h0000_0180, 32'h0000_0180);
      repeat (2) begin
         v = $random(seed);
         wr(8'h18, {16'h0000, v[15:0]});
         while (device_reply[1] !== 1'b1) @(posedge pclk);
         while (device_reply[1] !== 1'b0) @(posedge pclk);
         waitc(6);
         chk("peer_got", {16'h0000, v[15:0]}, {16'h0000, pb_got});
      end
      end_sim();
   end
endmodule
bind pph_port pph_checker chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pready(pready), .pslverr(pslverr), .io_out(io_out), .io_oe(io_oe),
   .device_ready(device_ready), .device_reply(device_reply));
